// ### logic/sfb_pkg.sv
package sfb_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_INSTR = 8'h04;
    localparam logic [7:0] OFF_FP = 8'h08;
    localparam logic [7:0] OFF_SP = 8'h0c;
    localparam logic [7:0] OFF_LIMIT = 8'h10;
    localparam logic [7:0] OFF_STAT = 8'h14;
    localparam logic [7:0] OFF_MASK = 8'h18;
    localparam logic [7:0] OFF_FCODE = 8'h1c;
    localparam logic [7:0] OFF_IP = 8'h20;
    // instruction encoding
    localparam logic [7:0] OPC_FRAME = 8'hc8;
    localparam int INSTR_OPC_LSB = 0;
    localparam int INSTR_SIZE_LSB = 8;
    localparam int INSTR_DEPTH_LSB = 24;
    localparam logic [31:0] INSTR_LEN = 32'h0000_0004;
    localparam logic [31:0] STEP_32 = 32'h0000_0004;
    localparam logic [31:0] STEP_16 = 32'h0000_0002;
    // control bit positions
    localparam int CTRL_START = 0;
    localparam int CTRL_STK32 = 1;
    localparam int CTRL_OP32 = 2;
    localparam int CTRL_PROT = 3;
    // status bit positions
    localparam int ST_DONE = 0;
    localparam int ST_SSF = 1;
    localparam int ST_PGF = 2;
    localparam int ST_BADOP = 3;
    localparam int ST_BUSY = 8;
    localparam int NUM_EV = 4;
    // values after reset
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [31:0] RST_LIMIT = 32'hffff_ffff;
    localparam logic [3:0] RST_MASK = 4'h0;

    typedef enum logic [2:0] {
        S_IDLE,
        S_PUSH_FP,
        S_RD_DISP,
        S_PUSH_DISP,
        S_PUSH_TMP,
        S_FINISH
    } sfb_state_e;

    typedef struct packed {
        logic req;
        logic we;
        logic wide;
        logic [31:0] addr;
        logic [31:0] wdata;
    } sfb_mem_s;
endpackage

// ### logic/sfb_frame_builder.sv
`timescale 1ns/100ps
module sfb_frame_builder
    import sfb_pkg::*;
(
    input wire logic pclk, // core clock
    input wire logic presetn, // async reset
    input wire logic ce, // clock enable
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb write
    input wire logic [7:0] paddr, // apb address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    output sfb_mem_s mem, // stack memory request
    input wire logic mem_ack, // memory done
    input wire logic [31:0] mem_rdata, // memory read data
    input wire logic mem_fault, // paging fault with ack
    input wire logic [31:0] mem_fault_code, // paging fault code
    output logic irq // interrupt level
);
    sfb_state_e state;
    logic stk32;
    logic op32;
    logic prot;
    logic [31:0] instr;
    logic [31:0] fp;
    logic [31:0] sp;
    logic [31:0] limit;
    logic [31:0] ip;
    logic [31:0] fcode;
    logic [31:0] wfp;
    logic [31:0] wsp;
    logic [31:0] tmp;
    logic [31:0] disp;
    logic [4:0] depth;
    logic [4:0] cnt;
    logic [NUM_EV-1:0] sticky;
    logic [NUM_EV-1:0] mask;

    function automatic logic [31:0] ptr(input logic [31:0] old,
        input logic [31:0] nv, input logic s32);
        ptr = s32 ? nv : {old[31:16], nv[15:0]};
    endfunction

    function automatic logic [31:0] adr(input logic [31:0] p,
        input logic s32);
        adr = s32 ? p : {16'h0000, p[15:0]};
    endfunction

    // apb decode
    wire logic setup = psel && !penable;
    wire logic acc = psel && penable && pready;
    wire logic wr = acc && pwrite && !pslverr;
    wire logic rd = acc && !pwrite && !pslverr;
    wire logic hit_ctrl = paddr == OFF_CTRL;
    wire logic hit_instr = paddr == OFF_INSTR;
    wire logic hit_fp = paddr == OFF_FP;
    wire logic hit_sp = paddr == OFF_SP;
    wire logic hit_limit = paddr == OFF_LIMIT;
    wire logic hit_stat = paddr == OFF_STAT;
    wire logic hit_mask = paddr == OFF_MASK;
    wire logic hit_fcode = paddr == OFF_FCODE;
    wire logic hit_ip = paddr == OFF_IP;
    wire logic mapped = hit_ctrl || hit_instr || hit_fp || hit_sp
        || hit_limit || hit_stat || hit_mask || hit_fcode || hit_ip;
    wire logic idle = state == S_IDLE;
    wire logic busy = !idle;
    wire logic [31:0] ctrl_rd = {28'h0000000, prot, op32, stk32, 1'b0};
    wire logic [31:0] stat_rd = {23'h000000, busy, 4'h0, sticky};
    wire logic [31:0] rdata_mux =
        hit_ctrl ? ctrl_rd :
        hit_instr ? instr :
        hit_fp ? fp :
        hit_sp ? sp :
        hit_limit ? limit :
        hit_stat ? stat_rd :
        hit_mask ? {28'h0000000, mask} :
        hit_fcode ? fcode :
        hit_ip ? ip : RST_WORD;
    wire logic wr_reg = wr && idle;

    // instruction fields
    wire logic [7:0] opc = instr[INSTR_OPC_LSB +: 8];
    wire logic [15:0] size = instr[INSTR_SIZE_LSB +: 16];
    wire logic [4:0] lvl = instr[INSTR_DEPTH_LSB +: 5];
    wire logic bad = opc != OPC_FRAME;
    wire logic start_req = wr && hit_ctrl && pwdata[CTRL_START] && idle;

    // datapath
    wire logic [31:0] step = op32 ? STEP_32 : STEP_16;
    wire logic [31:0] push_sp = ptr(wsp, wsp - step, stk32);
    wire logic [31:0] disp_fp = ptr(wfp, wfp - step, stk32);
    wire logic [31:0] new_sp = ptr(tmp, tmp - {16'h0000, size}, stk32);
    wire logic [31:0] new_fp = ptr(fp, tmp, stk32);
    wire logic ssf = prot && adr(new_sp, stk32) > limit;
    wire logic mem_go = mem.req && mem_ack;
    wire logic mem_st = state == S_PUSH_FP || state == S_RD_DISP
        || state == S_PUSH_DISP || state == S_PUSH_TMP;
    wire logic rd_st = state == S_RD_DISP;
    wire logic [31:0] req_addr = rd_st ? adr(disp_fp, stk32)
        : adr(push_sp, stk32);
    wire logic [31:0] req_data =
        state == S_PUSH_FP ? wfp :
        state == S_PUSH_DISP ? disp :
        tmp;
    wire logic fin = state == S_FINISH;

    // sticky events
    logic [NUM_EV-1:0] ev;
    assign ev[ST_DONE] = fin && !ssf;
    assign ev[ST_SSF] = fin && ssf;
    assign ev[ST_PGF] = mem_go && mem_fault;
    assign ev[ST_BADOP] = start_req && bad;
    // clear only what the read returned; later events survive
    wire logic [NUM_EV-1:0] clr =
        (rd && hit_stat) ? prdata[NUM_EV-1:0] : '0;
    wire logic [NUM_EV-1:0] next_sticky = (sticky & ~clr) | ev;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= RST_WORD;
        end else if (ce) begin
            pready <= setup;
            pslverr <= setup && !mapped;
            if (setup) begin
                prdata <= mapped ? rdata_mux : RST_WORD;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stk32 <= 1'b0;
            op32 <= 1'b0;
            prot <= 1'b0;
            instr <= RST_WORD;
            limit <= RST_LIMIT;
            mask <= RST_MASK;
        end else if (ce) begin
            if (wr_reg && hit_ctrl) begin
                stk32 <= pwdata[CTRL_STK32];
                op32 <= pwdata[CTRL_OP32];
                prot <= pwdata[CTRL_PROT];
            end
            if (wr_reg && hit_instr) begin
                instr <= pwdata;
            end
            if (wr_reg && hit_limit) begin
                limit <= pwdata;
            end
            if (wr && hit_mask) begin
                mask <= pwdata[NUM_EV-1:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sticky <= '0;
            irq <= 1'b0;
            fcode <= RST_WORD;
        end else if (ce) begin
            sticky <= next_sticky;
            irq <= |(next_sticky & mask);
            if (ev[ST_PGF]) begin
                fcode <= mem_fault_code;
            end else if (ev[ST_SSF]) begin
                fcode <= RST_WORD;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fp <= RST_WORD;
            sp <= RST_WORD;
            ip <= RST_WORD;
        end else if (ce) begin
            if (fin && !ssf) begin
                fp <= new_fp;
                sp <= new_sp;
                ip <= ip + INSTR_LEN;
            end else begin
                if (wr_reg && hit_fp) begin
                    fp <= pwdata;
                end
                if (wr_reg && hit_sp) begin
                    sp <= pwdata;
                end
                if (wr_reg && hit_ip) begin
                    ip <= pwdata;
                end
            end
        end
    end

    // sequencer and stack memory port
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= S_IDLE;
            mem <= '0;
            wfp <= RST_WORD;
            wsp <= RST_WORD;
            tmp <= RST_WORD;
            disp <= RST_WORD;
            depth <= 5'h00;
            cnt <= 5'h00;
        end else if (ce) begin
            if (mem_st && !mem.req) begin
                mem <= '{1'b1, !rd_st, op32, req_addr, req_data};
            end else if (mem_go) begin
                mem.req <= 1'b0;
            end
            case (state)
                S_IDLE: begin
                    if (start_req && !bad) begin
                        state <= S_PUSH_FP;
                        wfp <= fp;
                        wsp <= sp;
                        depth <= lvl;
                        cnt <= lvl - 5'h01;
                    end
                end
                S_PUSH_FP: begin
                    if (mem_go) begin
                        wsp <= push_sp;
                        tmp <= push_sp;
                        if (mem_fault) begin
                            state <= S_IDLE;
                        end else if (depth == 5'h00) begin
                            state <= S_FINISH;
                        end else if (cnt == 5'h00) begin
                            state <= S_PUSH_TMP;
                        end else begin
                            state <= S_RD_DISP;
                        end
                    end
                end
                S_RD_DISP: begin
                    if (mem_go) begin
                        wfp <= disp_fp;
                        disp <= mem_rdata;
                        state <= mem_fault ? S_IDLE : S_PUSH_DISP;
                    end
                end
                S_PUSH_DISP: begin
                    if (mem_go) begin
                        wsp <= push_sp;
                        cnt <= cnt - 5'h01;
                        if (mem_fault) begin
                            state <= S_IDLE;
                        end else if (cnt == 5'h01) begin
                            state <= S_PUSH_TMP;
                        end else begin
                            state <= S_RD_DISP;
                        end
                    end
                end
                S_PUSH_TMP: begin
                    if (mem_go) begin
                        wsp <= push_sp;
                        state <= mem_fault ? S_IDLE : S_FINISH;
                    end
                end
                S_FINISH: begin
                    state <= S_IDLE;
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn || !ce);

    sequence s_fin_ok;
        fin && !ssf;
    endsequence

    sequence s_go_ok;
        mem_go && !mem_fault;
    endsequence

    property p_decode;
        start_req |=> (bad ? idle && sticky[ST_BADOP]
            : state == S_PUSH_FP);
    endproperty
    a_decode: assert property (p_decode)
        else $error("frame start decode wrong");

    property p_size;
        s_fin_ok |=> sp == $past(new_sp) && fp == $past(new_fp);
    endproperty
    a_size: assert property (p_size)
        else $error("new sp not fp minus size");

    property p_depth;
        start_req && !bad |=> depth == $past(lvl)
            && cnt == $past(lvl) - 5'h01;
    endproperty
    a_depth: assert property (p_depth)
        else $error("depth not level mod 32");

    property p_ptr16;
        s_fin_ok and !stk32 |=> sp[31:16] == $past(sp[31:16]);
    endproperty
    a_ptr16: assert property (p_ptr16)
        else $error("16-bit stack touched upper half");

    property p_next_ip;
        s_fin_ok |=> ip == $past(ip) + INSTR_LEN ##1 idle;
    endproperty
    a_next_ip: assert property (p_next_ip)
        else $error("ip not advanced by one instruction");

    property p_level0;
        s_go_ok and state == S_PUSH_FP && depth == 5'h00
            |=> fin ##1 idle;
    endproperty
    a_level0: assert property (p_level0)
        else $error("plain frame sequence wrong");

    property p_nest;
        s_go_ok and state == S_PUSH_DISP && cnt == 5'h01
            |=> state == S_PUSH_TMP;
    endproperty
    a_nest: assert property (p_nest)
        else $error("display copy count wrong");

    property p_tmp;
        mem.req && state == S_PUSH_TMP |-> mem.wdata == tmp && mem.we;
    endproperty
    a_tmp: assert property (p_tmp)
        else $error("saved frame value push wrong");

    property p_step;
        s_go_ok and mem.we |=> wsp == $past(push_sp)
            && $past(mem.wide) == $past(op32);
    endproperty
    a_step: assert property (p_step)
        else $error("push step wrong");

    property p_ssf;
        fin && ssf |=> sticky[ST_SSF] && fcode == RST_WORD
            && sp == $past(sp);
    endproperty
    a_ssf: assert property (p_ssf)
        else $error("stack fault not raised cleanly");

    property p_pgf;
        mem_go && mem_fault |=> idle && sticky[ST_PGF]
            && fcode == $past(mem_fault_code);
    endproperty
    a_pgf: assert property (p_pgf)
        else $error("page fault not raised");

    property p_real;
        fin && !prot |-> !ev[ST_SSF];
    endproperty
    a_real: assert property (p_real)
        else $error("fault raised outside protected mode");
endmodule

// ### verification/sfb_frame_builder_tb_top.sv
`timescale 1ns/100ps
module sfb_frame_builder_tb_top;
    import sfb_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic mem_ack, mem_fault, irq, er, flt_on;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, mem_rdata, mem_fault_code, rd;
    sfb_mem_s mem;
    logic [31:0] marr [logic [31:0]];
    logic [31:0] wa[$];
    logic [31:0] wd[$];
    logic ww[$];
    int failures, compares, cyc, dly, wcnt;

    sfb_frame_builder i_dut (
        .pclk(pclk), .presetn(presetn), .ce(1'b1),
        .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .mem(mem),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata),
        .mem_fault(mem_fault), .mem_fault_code(mem_fault_code),
        .irq(irq)
    );

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    // stack memory: answers after dly cycles, scrambles idle data
    always @(posedge pclk) begin
        if (mem.req && !mem_ack && wcnt >= dly) begin
            mem_ack <= 1'b1;
            mem_fault <= flt_on;
            mem_fault_code <= flt_on ? 32'h0000_0006 : ~mem_fault_code;
            mem_rdata <= mem.we ? ~mem_rdata : marr[mem.addr];
            wcnt <= 0;
            if (mem.we) begin
                wa.push_back(mem.addr);
                wd.push_back(mem.wdata);
                ww.push_back(mem.wide);
            end
        end else begin
            mem_ack <= 1'b0;
            mem_fault <= 1'b0;
            mem_fault_code <= ~mem_fault_code;
            mem_rdata <= ~mem_rdata;
            wcnt <= mem.req ? wcnt + 1 : 0;
        end
    end

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            stop_test();
        end
    end

    task automatic stop_test();
        if (failures == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    task automatic regs(input logic [31:0] fp, input logic [31:0] sp);
        apb(1'b1, OFF_FP, fp);
        apb(1'b1, OFF_SP, sp);
    endtask

    // start one instruction, wait for the interrupt, read status
    task automatic run(input logic [31:0] ins, input logic [3:0] ctl);
        int n;
        wa.delete();
        wd.delete();
        ww.delete();
        apb(1'b1, OFF_INSTR, ins);
        apb(1'b1, OFF_CTRL, {28'h0, ctl} | 32'h1);
        n = 0;
        while (irq !== 1'b1 && n < 300) begin
            @(posedge pclk);
            n++;
        end
        apb(1'b0, OFF_STAT, 32'h0);
    endtask

    task automatic chkw(input int i, input logic [31:0] a,
                        input logic [31:0] d, input logic w);
        chk(wa[i], a);
        chk(w ? wd[i] : {16'h0, wd[i][15:0]}, d);
        chk({31'h0, ww[i]}, {31'h0, w});
    endtask

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        mem_ack = 1'b0;
        mem_fault = 1'b0;
        mem_rdata = 32'h0;
        mem_fault_code = 32'h0;
        flt_on = 1'b0;
        dly = 0;
        wcnt = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdchk(OFF_LIMIT, RST_LIMIT);
        rdchk(OFF_MASK, RST_WORD);
        rdchk(OFF_IP, RST_WORD);
        apb(1'b0, 8'h40, 32'h0);
        chk({31'h0, er}, 32'h1);
        chk(rd, 32'h0);
        apb(1'b1, OFF_MASK, 32'hf);
        // plain frame, slow memory
        dly <= 3;
        regs(32'h1234, 32'h100);
        run({8'h00, 16'h0020, OPC_FRAME}, 4'h6);
        chk(rd, 32'h1);
        @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        chkw(0, 32'hfc, 32'h1234, 1'b1);
        chk(32'(wa.size()), 32'h1);
        rdchk(OFF_FP, 32'hfc);
        rdchk(OFF_SP, 32'hdc);
        rdchk(OFF_IP, 32'h4);
        // level 35 acts as 3
        dly <= 0;
        marr[32'h1fc] = 32'haaaa_0001;
        marr[32'h1f8] = 32'hbbbb_0002;
        regs(32'h200, 32'h300);
        run({8'h23, 16'h0010, OPC_FRAME}, 4'h6);
        chk(rd, 32'h1);
        chkw(0, 32'h2fc, 32'h200, 1'b1);
        chkw(1, 32'h2f8, 32'haaaa_0001, 1'b1);
        chkw(2, 32'h2f4, 32'hbbbb_0002, 1'b1);
        chkw(3, 32'h2f0, 32'h2fc, 1'b1);
        chk(32'(wa.size()), 32'h4);
        rdchk(OFF_FP, 32'h2fc);
        rdchk(OFF_SP, 32'h2ec);
        // 16-bit stack and operands, level 2
        marr[32'h3e] = 32'h0000_5a5a;
        regs(32'h40, 32'h80);
        run({8'h02, 16'h0004, OPC_FRAME}, 4'h0);
        chkw(0, 32'h7e, 32'h40, 1'b0);
        chkw(1, 32'h7c, 32'h5a5a, 1'b0);
        chkw(2, 32'h7a, 32'h7e, 1'b0);
        rdchk(OFF_FP, 32'h7e);
        rdchk(OFF_SP, 32'h7a);
        // level 1: no display copies
        regs(32'h400, 32'h500);
        run({8'h01, 16'h0000, OPC_FRAME}, 4'h2);
        chkw(0, 32'h4fe, 32'h400, 1'b0);
        chkw(1, 32'h4fc, 32'h4fe, 1'b0);
        chk(32'(wa.size()), 32'h2);
        rdchk(OFF_SP, 32'h4fe);
        // limit check only in protected mode
        apb(1'b1, OFF_LIMIT, 32'h50);
        regs(32'h10, 32'h100);
        run({8'h00, 16'h0010, OPC_FRAME}, 4'he);
        chk(rd & 32'he, 32'h2);
        rdchk(OFF_FCODE, 32'h0);
        rdchk(OFF_SP, 32'h100);
        rdchk(OFF_IP, 32'h10);
        run({8'h00, 16'h0010, OPC_FRAME}, 4'h6);
        chk(rd & 32'he, 32'h0);
        rdchk(OFF_SP, 32'hec);
        // paging fault on the first push
        flt_on <= 1'b1;
        regs(32'h10, 32'h100);
        run({8'h00, 16'h0010, OPC_FRAME}, 4'h6);
        flt_on <= 1'b0;
        chk(rd & 32'he, 32'h4);
        rdchk(OFF_FCODE, 32'h6);
        rdchk(OFF_SP, 32'h100);
        rdchk(OFF_IP, 32'h14);
        // foreign opcode, masked then unmasked
        apb(1'b1, OFF_MASK, 32'h0);
        apb(1'b1, OFF_INSTR, {8'h00, 16'h0010, 8'h90});
        apb(1'b1, OFF_CTRL, 32'h7);
        repeat (10) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, OFF_MASK, 32'h8);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h1);
        apb(1'b0, OFF_STAT, 32'h0);
        chk(rd & 32'he, 32'h8);
        rdchk(OFF_IP, 32'h14);
        stop_test();
    end
endmodule
